// ---- rtl/data_memory_access_unit_consts.vh ----
`ifndef DATA_MEMORY_ACCESS_UNIT_CONSTS_VH
`define DATA_MEMORY_ACCESS_UNIT_CONSTS_VH
`define SFR_PTR0_LOW     8'h82
`define SFR_PTR0_HIGH    8'h83
`define SFR_PTR1_LOW     8'h84
`define SFR_PTR1_HIGH    8'h85
`define SFR_PTR_SELECT   8'h86
`define SFR_CLOCK_CTRL   8'h8e
`define SFR_POWER_MGMT   8'hc4
`define CLOCK_CTRL_RESET 8'h01
`define POWER_MGMT_RESET 8'h00
`define STRETCH_LSB      0
`define STRETCH_MSB      2
`define DME_LSB          0
`define DME_MSB          1
`define SRAM_TOP         16'h03ff
`define LOCK_STATUS_ADDR 16'hfffc
`define CLOCKS_PER_MC    4'd4
`define ADDR_CLOCKS      6'd3
`define INT_CLOCKS       6'd8
`endif

// ---- rtl/data_sram.v ----
`timescale 1ns/1ns
module data_sram (
    input  wire       clk,
    input  wire       wr_en,
    input  wire [9:0] addr,
    input  wire [7:0] wdata,
    output reg  [7:0] rdata
);
    reg [7:0] mem [0:1023];
    // no reset: contents survive any change of the map
    always @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ---- rtl/pointer_pair.v ----
`timescale 1ns/1ns
module pointer_pair (
    input  wire        clk,
    input  wire        rst,
    input  wire        sel,
    input  wire        wr_low0,
    input  wire        wr_high0,
    input  wire        wr_low1,
    input  wire        wr_high1,
    input  wire [7:0]  wdata,
    input  wire        load,
    input  wire [15:0] load_value,
    input  wire        incr,
    output reg  [15:0] ptr0,
    output reg  [15:0] ptr1,
    output wire [15:0] active
);
    assign active = sel ? ptr1 : ptr0;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr0 <= 16'h0000;
            ptr1 <= 16'h0000;
        end else if (load || incr) begin
            if (sel) begin
                ptr1 <= load ? load_value : ptr1 + 16'h0001;
            end else begin
                ptr0 <= load ? load_value : ptr0 + 16'h0001;
            end
        end else begin
            if (wr_low0) ptr0[7:0] <= wdata;
            if (wr_high0) ptr0[15:8] <= wdata;
            if (wr_low1) ptr1[7:0] <= wdata;
            if (wr_high1) ptr1[15:8] <= wdata;
        end
    end
endmodule

// ---- rtl/data_memory_access_unit.v ----
// Contract
// - map enabled: 0000h-03FFh accesses go to on-chip SRAM.
// - map enabled: addresses above 03FFh go out on the external bus.
// - map disabled (reset): every address goes to the external bus.
// - enable field sits in bits 1:0 of register C4h.
// - code 11: SRAM low, lock byte at FFFCh, no external access else.
// - lock byte bits 2:0 show programmed lock bits; read-only.
// - enable field may change anytime, taking effect at once.
// - SRAM contents survive enable field changes.
// - internal SRAM accesses always take two machine cycles.
// - stretch value is bits 2:0 of register 8Eh.
// - external access takes stretch plus two machine cycles.
// - reset stretch is 1, three machine cycles.
// - strobe width 2 clocks at stretch 0, else four per step.
// - nonzero stretch adds one clock of setup and hold.
// - stretch affects data accesses only, never program fetch.
// - two 16-bit pointers at 82h/83h and 84h/85h.
// - bit 0 of 86h selects pointer; other bits read zero.
// - pointer operations use the currently selected pointer.
`timescale 1ns/1ns
`include "data_memory_access_unit_consts.vh"
module data_memory_access_unit (
    input  wire        clk,
    input  wire        rst,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    output reg  [7:0]  sfr_rdata,
    input  wire        ptr_load,
    input  wire [15:0] ptr_load_value,
    input  wire        ptr_incr,
    input  wire        xdata_req,
    input  wire        xdata_we,
    input  wire        xdata_use_ptr,
    input  wire [15:0] xdata_addr,
    input  wire [7:0]  xdata_wdata,
    output reg  [7:0]  xdata_rdata,
    output reg         xdata_done,
    output reg         xdata_busy,
    input  wire [2:0]  security_lock_bits,
    output reg  [7:0]  p0_out,
    output reg         p0_oe,
    input  wire [7:0]  p0_in,
    output reg  [7:0]  p2_out,
    output reg         ale,
    output reg         rd_n,
    output reg         wr_n
);
    localparam ST_IDLE   = 3'd0;
    localparam ST_INT    = 3'd1;
    localparam ST_ADDR   = 3'd2;
    localparam ST_SETUP  = 3'd3;
    localparam ST_STROBE = 3'd4;
    localparam ST_HOLD   = 3'd5;
    localparam ST_TAIL   = 3'd6;

    reg  [7:0]  clock_ctrl;
    reg  [7:0]  power_mgmt;
    reg         ptr_sel;
    reg  [2:0]  state;
    reg  [5:0]  count;
    reg  [5:0]  tail_len;
    reg         we_lat;
    reg  [7:0]  wdata_lat;
    reg  [1:0]  target;
    reg  [1:0]  next_target;
    reg         sram_wr;
    reg  [9:0]  sram_addr;
    wire [7:0]  sram_rdata;
    wire [15:0] ptr0;
    wire [15:0] ptr1;
    wire [15:0] ptr_active;
    wire [15:0] acc_addr;
    wire [2:0]  stretch;
    wire [1:0]  dme;

    assign stretch = clock_ctrl[`STRETCH_MSB:`STRETCH_LSB];
    assign dme = power_mgmt[`DME_MSB:`DME_LSB];
    assign acc_addr = xdata_use_ptr ? ptr_active : xdata_addr;

    // one lookup shared by the latch and the branch on accept
    always @* begin
        next_target = decode(dme, acc_addr);
    end

    // target: 0 external, 1 sram, 2 lock byte, 3 no access
    function [1:0] decode;
        input [1:0]  mode;
        input [15:0] a;
        begin
            if (mode == 2'b01) begin
                decode = (a <= `SRAM_TOP) ? 2'd1 : 2'd0;
            end else if (mode == 2'b11) begin
                if (a <= `SRAM_TOP)
                    decode = 2'd1;
                else if (a == `LOCK_STATUS_ADDR)
                    decode = 2'd2;
                else
                    decode = 2'd3;
            end else begin
                decode = 2'd0;
            end
        end
    endfunction

    // strobe clocks: 2 at stretch 0, 4*s otherwise
    function [5:0] strobe_clocks;
        input [2:0] s;
        begin
            if (s == 3'd0)
                strobe_clocks = 6'd2;
            else
                strobe_clocks = {1'b0, s, 2'b00};
        end
    endfunction

    // whole external access: stretch plus two machine cycles
    function [5:0] access_clocks;
        input [2:0] s;
        begin
            access_clocks = ({3'b000, s} + 6'd2)
                            * {2'b00, `CLOCKS_PER_MC};
        end
    endfunction

    // clocks after the strobe; a stretched access spends one each on
    // extra setup and hold
    function [5:0] tail_clocks;
        input [2:0] s;
        begin
            if (s == 3'd0)
                tail_clocks = access_clocks(s) - strobe_clocks(s)
                              - `ADDR_CLOCKS;
            else
                tail_clocks = access_clocks(s) - strobe_clocks(s)
                              - `ADDR_CLOCKS - 6'd2;
        end
    endfunction

    pointer_pair u_ptrs (
        .clk        (clk),
        .rst        (rst),
        .sel        (ptr_sel),
        .wr_low0    (sfr_wr && sfr_addr == `SFR_PTR0_LOW),
        .wr_high0   (sfr_wr && sfr_addr == `SFR_PTR0_HIGH),
        .wr_low1    (sfr_wr && sfr_addr == `SFR_PTR1_LOW),
        .wr_high1   (sfr_wr && sfr_addr == `SFR_PTR1_HIGH),
        .wdata      (sfr_wdata),
        .load       (ptr_load),
        .load_value (ptr_load_value),
        .incr       (ptr_incr),
        .ptr0       (ptr0),
        .ptr1       (ptr1),
        .active     (ptr_active)
    );

    data_sram u_sram (
        .clk   (clk),
        .wr_en (sram_wr),
        .addr  (sram_addr),
        .wdata (wdata_lat),
        .rdata (sram_rdata)
    );

    // lock straps are asynchronous levels; three stages, accept on agree
    reg [2:0] lock_s1;
    reg [2:0] lock_s2;
    reg [2:0] lock_s3;
    reg [2:0] lock_bits;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_s1   <= 3'b000;
            lock_s2   <= 3'b000;
            lock_s3   <= 3'b000;
            lock_bits <= 3'b000;
        end else begin
            lock_s1 <= security_lock_bits;
            lock_s2 <= lock_s1;
            lock_s3 <= lock_s2;
            if (lock_s2 == lock_s3)
                lock_bits <= lock_s3;
        end
    end

    // register file
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_ctrl <= `CLOCK_CTRL_RESET;
            power_mgmt <= `POWER_MGMT_RESET;
            ptr_sel    <= 1'b0;
            sfr_rdata  <= 8'h00;
        end else begin
            if (sfr_wr) begin
                if (sfr_addr == `SFR_CLOCK_CTRL)
                    clock_ctrl <= sfr_wdata;
                else if (sfr_addr == `SFR_POWER_MGMT)
                    power_mgmt <= sfr_wdata;
                else if (sfr_addr == `SFR_PTR_SELECT)
                    ptr_sel <= sfr_wdata[0];
            end
            if (sfr_rd) begin
                if (sfr_addr == `SFR_PTR0_LOW)
                    sfr_rdata <= ptr0[7:0];
                else if (sfr_addr == `SFR_PTR0_HIGH)
                    sfr_rdata <= ptr0[15:8];
                else if (sfr_addr == `SFR_PTR1_LOW)
                    sfr_rdata <= ptr1[7:0];
                else if (sfr_addr == `SFR_PTR1_HIGH)
                    sfr_rdata <= ptr1[15:8];
                else if (sfr_addr == `SFR_PTR_SELECT)
                    sfr_rdata <= {7'b0000000, ptr_sel};
                else if (sfr_addr == `SFR_CLOCK_CTRL)
                    sfr_rdata <= clock_ctrl;
                else if (sfr_addr == `SFR_POWER_MGMT)
                    sfr_rdata <= power_mgmt;
                else
                    sfr_rdata <= 8'h00;
            end
        end
    end

    // access sequencer; one machine cycle is four clocks
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= ST_IDLE;
            count       <= 6'd0;
            tail_len    <= 6'd0;
            we_lat      <= 1'b0;
            wdata_lat   <= 8'h00;
            target      <= 2'd0;
            sram_wr     <= 1'b0;
            sram_addr   <= 10'h000;
            xdata_rdata <= 8'h00;
            xdata_done  <= 1'b0;
            xdata_busy  <= 1'b0;
            p0_out      <= 8'h00;
            p0_oe       <= 1'b0;
            p2_out      <= 8'h00;
            ale         <= 1'b0;
            rd_n        <= 1'b1;
            wr_n        <= 1'b1;
        end else begin
            xdata_done <= 1'b0;
            sram_wr    <= 1'b0;
            ale        <= 1'b0;
            case (state)
            ST_IDLE: begin
                if (xdata_req) begin
                    // map sampled per access, so a new code acts at once
                    target     <= next_target;
                    we_lat     <= xdata_we;
                    wdata_lat  <= xdata_wdata;
                    sram_addr  <= acc_addr[9:0];
                    xdata_busy <= 1'b1;
                    count      <= 6'd0;
                    if (next_target == 2'd0) begin
                        state  <= ST_ADDR;
                        ale    <= 1'b1;
                        p0_out <= acc_addr[7:0];
                        p0_oe  <= 1'b1;
                        p2_out <= acc_addr[15:8];
                    end else begin
                        state <= ST_INT;
                    end
                end
            end
            ST_INT: begin
                // fixed 8 clocks, stretch ignored
                count <= count + 6'd1;
                if (count == 6'd0 && target == 2'd1 && we_lat)
                    sram_wr <= 1'b1;
                if (count == `INT_CLOCKS - 6'd2) begin
                    if (target == 2'd1)
                        xdata_rdata <= sram_rdata;
                    else if (target == 2'd2)
                        xdata_rdata <= {5'b00000, lock_bits};
                    else
                        xdata_rdata <= 8'hff;
                end
                if (count == `INT_CLOCKS - 6'd1) begin
                    state      <= ST_IDLE;
                    xdata_done <= 1'b1;
                    xdata_busy <= 1'b0;
                end
            end
            ST_ADDR: begin
                count <= count + 6'd1;
                if (count == `ADDR_CLOCKS - 6'd1) begin
                    count <= 6'd0;
                    if (we_lat)
                        p0_out <= wdata_lat;
                    else
                        p0_oe <= 1'b0;
                    state <= (stretch != 3'd0) ? ST_SETUP : ST_STROBE;
                    if (stretch == 3'd0) begin
                        rd_n <= we_lat;
                        wr_n <= ~we_lat;
                    end
                end
            end
            ST_SETUP: begin
                state <= ST_STROBE;
                rd_n  <= we_lat;
                wr_n  <= ~we_lat;
            end
            ST_STROBE: begin
                count <= count + 6'd1;
                if (count == strobe_clocks(stretch) - 6'd1) begin
                    count <= 6'd0;
                    if (!we_lat)
                        xdata_rdata <= p0_in;
                    rd_n <= 1'b1;
                    wr_n <= 1'b1;
                    tail_len <= tail_clocks(stretch);
                    state <= (stretch != 3'd0) ? ST_HOLD : ST_TAIL;
                end
            end
            ST_HOLD: begin
                state <= ST_TAIL;
            end
            ST_TAIL: begin
                count <= count + 6'd1;
                if (count + 6'd1 == tail_len) begin
                    state      <= ST_IDLE;
                    p0_oe      <= 1'b0;
                    xdata_done <= 1'b1;
                    xdata_busy <= 1'b0;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
            endcase
        end
    end
    // program fetches never pass through this sequencer
endmodule

// ---- verification/data_memory_access_unit_assertions.sv ----
`timescale 1ns/1ns
module dmau_checker (
    input wire        clk,
    input wire        rst,
    input wire        sfr_wr,
    input wire        sfr_rd,
    input wire [7:0]  sfr_addr,
    input wire [7:0]  sfr_wdata,
    input wire [7:0]  sfr_rdata,
    input wire        xdata_req,
    input wire        xdata_use_ptr,
    input wire [15:0] xdata_addr,
    input wire        xdata_done,
    input wire        xdata_busy,
    input wire        p0_oe,
    input wire        ale,
    input wire        rd_n,
    input wire        wr_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // shadow copies, so the checker sees only port traffic
    reg [2:0] st;
    reg [1:0] code;
    reg [4:0] low_len;
    reg [3:0] gap;
    wire       strobe = !rd_n || !wr_n;
    wire [4:0] exp_w = (st == 3'h0) ? 5'h02 : {st, 2'b00};
    wire       take = xdata_req && !xdata_busy && !xdata_use_ptr;
    wire       inner = code == 2'h3 || (code == 2'h1 && xdata_addr <= 16'h03ff);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= 3'h1;
            code <= 2'h0;
            low_len <= 5'h00;
            gap <= 4'h0;
        end else begin
            if (sfr_wr && sfr_addr == 8'h8e) st <= sfr_wdata[2:0];
            if (sfr_wr && sfr_addr == 8'hc4) code <= sfr_wdata[1:0];
            low_len <= strobe ? low_len + 5'h01 : 5'h00;
            // saturates so a long idle never wraps to a false match
            gap <= ale ? 4'h0 : gap + {3'h0, gap != 4'hf};
        end
    end
    property p_int_quiet;
        take && inner |-> (!ale && rd_n && wr_n) [*8];
    endproperty
    a_int_quiet: assert property (p_int_quiet)
        else $error("bus active on internal access");
    property p_int_time;
        take && inner |-> ##9 xdata_done;
    endproperty
    a_int_time: assert property (p_int_time)
        else $error("internal access length wrong");
    property p_ext_go;
        take && !inner |-> ##[1:3] ale;
    endproperty
    a_ext_go: assert property (p_ext_go)
        else $error("external access not started");
    property p_width;
        $rose(rd_n) || $rose(wr_n) |-> low_len == exp_w;
    endproperty
    a_width: assert property (p_width)
        else $error("strobe width wrong");
    property p_setup;
        $fell(rd_n) || $fell(wr_n) |-> gap == ((st == 3'h0) ? 4'h2 : 4'h3);
    endproperty
    a_setup: assert property (p_setup)
        else $error("address setup wrong");
    property p_rd_oe;
        !rd_n |-> !p0_oe;
    endproperty
    a_rd_oe: assert property (p_rd_oe)
        else $error("bus driven during read");
    property p_wr_oe;
        !wr_n |-> p0_oe;
    endproperty
    a_wr_oe: assert property (p_wr_oe)
        else $error("bus released during write");
    property p_sel_zero;
        sfr_rd && sfr_addr == 8'h86 |=> sfr_rdata[7:1] == 7'h00;
    endproperty
    a_sel_zero: assert property (p_sel_zero)
        else $error("select upper bits not zero");
    c_int: cover property (take && inner);
    c_rd: cover property ($rose(rd_n));
    c_wr: cover property ($rose(wr_n));
    c_s7: cover property ($rose(rd_n) && st == 3'h7);
endmodule
bind data_memory_access_unit dmau_checker u_chk (
    .clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .xdata_req(xdata_req), .xdata_use_ptr(xdata_use_ptr),
    .xdata_addr(xdata_addr), .xdata_done(xdata_done),
    .xdata_busy(xdata_busy), .p0_oe(p0_oe), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n)
);

// ---- verification/ext_mem_model.sv ----
`timescale 1ns/1ns
module ext_mem_model (
    input  wire        clk,
    input  wire [7:0]  p0_out,
    input  wire        p0_oe,
    input  wire [7:0]  p2_out,
    input  wire        ale,
    input  wire        rd_n,
    input  wire        wr_n,
    output reg  [7:0]  p0_in,
    output reg  [15:0] last_addr,
    output integer     n_ext,
    output integer     strobe_w
);
    logic [7:0] mem [0:65535];
    integer     run;
    initial begin
        p0_in = 8'h00;
        last_addr = 16'h0000;
        n_ext = 0;
        strobe_w = 0;
        run = 0;
    end
    always @(posedge clk) begin
        if (ale) begin
            last_addr <= {p2_out, p0_out};
            n_ext <= n_ext + 1;
        end
        if (!rd_n || !wr_n) begin
            run <= run + 1;
        end else if (run != 0) begin
            strobe_w <= run;
            run <= 0;
        end
        if (!wr_n && p0_oe) mem[last_addr] <= p0_out;
        // undriven bus keeps changing so a stale capture shows up
        p0_in <= rd_n ? ~p0_in : mem[last_addr];
    end
endmodule

// ---- verification/data_memory_access_unit_test.sv ----
`timescale 1ns/1ns
module data_memory_access_unit_test;
    logic        clk, rst, sfr_wr, sfr_rd, ptr_load, ptr_incr;
    logic        xdata_req, xdata_we, xdata_use_ptr;
    logic [7:0]  sfr_addr, sfr_wdata, xdata_wdata, q;
    logic [15:0] ptr_load_value, xdata_addr;
    logic [2:0]  security_lock_bits;
    wire  [7:0]  sfr_rdata, xdata_rdata, p0_out, p0_in, p2_out;
    wire         xdata_done, xdata_busy, p0_oe, ale, rd_n, wr_n;
    wire  [15:0] last_addr;
    integer      n_ext, strobe_w, fails, n_tests, n, e;
    data_memory_access_unit uut (
        .clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .ptr_load(ptr_load), .ptr_load_value(ptr_load_value),
        .ptr_incr(ptr_incr), .xdata_req(xdata_req), .xdata_we(xdata_we),
        .xdata_use_ptr(xdata_use_ptr), .xdata_addr(xdata_addr),
        .xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata),
        .xdata_done(xdata_done), .xdata_busy(xdata_busy),
        .security_lock_bits(security_lock_bits), .p0_out(p0_out),
        .p0_oe(p0_oe), .p0_in(p0_in), .p2_out(p2_out), .ale(ale),
        .rd_n(rd_n), .wr_n(wr_n));
    ext_mem_model far (
        .clk(clk), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out),
        .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .p0_in(p0_in),
        .last_addr(last_addr), .n_ext(n_ext), .strobe_w(strobe_w));
    task complete_run;
        if (fails == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input [15:0] g, input [15:0] x);
        n_tests++;
        if (g !== x) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic sw(input [7:0] a, input [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic sr(input [7:0] a, input [7:0] x);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        chk(sfr_rdata, x);
    endtask
    task automatic xa(input w, input p, input [15:0] a, input [7:0] d);
        @(negedge clk);
        {xdata_we, xdata_use_ptr, xdata_addr, xdata_wdata} = {w, p, a, d};
        xdata_req = 1'b1;
        @(negedge clk);
        xdata_req = 1'b0;
        n = 0;
        while (xdata_done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n < 100), 16'h0001);
        q = xdata_rdata;
    endtask
    task t_reset;
        sr(8'h8e, 8'h01);
        sr(8'hc4, 8'h00);
        sr(8'h86, 8'h00);
        sr(8'h90, 8'h00);
        xa(1'b1, 1'b0, 16'h0010, 8'ha5);
        chk(16'(strobe_w), 16'h0004);
        chk(last_addr, 16'h0010);
        chk(16'(n), 16'h000c);
        xa(1'b1, 1'b0, 16'h0400, 8'h77);
    endtask
    task t_map;
        sw(8'hc4, 8'h01);
        e = n_ext;
        xa(1'b1, 1'b0, 16'h0010, 8'h5a);
        xa(1'b0, 1'b0, 16'h0010, 8'h00);
        chk(q, 8'h5a);
        chk(16'(n_ext - e), 16'h0000);
        xa(1'b0, 1'b0, 16'h0400, 8'h00);
        chk(q, 8'h77);
        sw(8'hc4, 8'h02);
        xa(1'b0, 1'b0, 16'h0010, 8'h00);
        chk(q, 8'ha5);
        sw(8'hc4, 8'h03);
        e = n_ext;
        xa(1'b1, 1'b0, 16'hfffc, 8'hff);
        xa(1'b0, 1'b0, 16'hfffc, 8'h00);
        chk(q, 8'h05);
        xa(1'b0, 1'b0, 16'hfffb, 8'h00);
        chk(q, 8'hff);
        xa(1'b0, 1'b0, 16'hfffd, 8'h00);
        chk(q, 8'hff);
        chk(16'(n_ext - e), 16'h0000);
        sw(8'hc4, 8'h01);
        xa(1'b0, 1'b0, 16'h0010, 8'h00);
        chk(q, 8'h5a);
    endtask
    task t_stretch;
        for (int s = 0; s < 8; s++) begin
            sw(8'h8e, 8'(s));
            sr(8'h8e, 8'(s));
            xa(1'b1, 1'b0, 16'h2000 + 16'(s), 8'(s) ^ 8'h3c);
            chk(16'(n), 16'(4 * (s + 2)));
            chk(16'(strobe_w), s != 0 ? 16'(4 * s) : 16'h0002);
            xa(1'b0, 1'b0, 16'h2000 + 16'(s), 8'h00);
            chk(q, 8'(s) ^ 8'h3c);
        end
        xa(1'b0, 1'b0, 16'h0010, 8'h00);
        chk(16'(n), 16'h0008);
    endtask
    task t_ptr;
        sw(8'hc4, 8'h00);
        sw(8'h82, 8'h11);
        sw(8'h83, 8'h22);
        sw(8'h84, 8'h33);
        sw(8'h85, 8'h44);
        sr(8'h82, 8'h11);
        sr(8'h85, 8'h44);
        sw(8'h86, 8'hff);
        sr(8'h86, 8'h01);
        @(negedge clk);
        ptr_load_value = 16'h0123;
        ptr_load = 1'b1;
        @(negedge clk);
        ptr_load = 1'b0;
        ptr_incr = 1'b1;
        @(negedge clk);
        ptr_incr = 1'b0;
        sr(8'h84, 8'h24);
        sr(8'h83, 8'h22);
        xa(1'b0, 1'b1, 16'h0000, 8'h00);
        chk(last_addr, 16'h0124);
        sw(8'h86, 8'h00);
        xa(1'b0, 1'b1, 16'h0000, 8'h00);
        chk(last_addr, 16'h2211);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {sfr_wr, sfr_rd, ptr_load, ptr_incr, xdata_req} = 5'h00;
        {xdata_we, xdata_use_ptr, sfr_addr, sfr_wdata} = 18'h00000;
        {xdata_addr, xdata_wdata, ptr_load_value} = 40'h0;
        security_lock_bits = 3'b101;
        fails = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_map;
        t_stretch;
        t_ptr;
        complete_run;
    end
    initial begin
        #100000;
        fails++;
        complete_run;
    end
endmodule
